// ==== rtl/dtc_pkg.sv ====
// Constants, types and register map of the dual timer/counter block
//=====================================================================
// Behaviour
// - Timer 1 overflow sets control bit 7 unless Timer 0 is split
// - Timer 0 overflow sets control bit 5
// - Control bit 6 runs Timer 1
// - Control bit 4 runs Timer 0
// - Ext irq 1 flag set per type bit
// - Level mode: irq 1 flag is inverted pin
// - Bit 2: irq 1 level or falling edge
// - Ext irq 0 flag set per type bit
// - Level mode: irq 0 flag is inverted pin
// - Bit 0: irq 0 level or falling edge
// - Timer 1 gate needs irq 1 pin high
// - Timer 0 gate needs irq 0 pin high
// - Timer 1 counts prescaled clock or pin edges
// - Timer 0 counts prescaled clock or pin edges
// - Timer 1 mode: 13, 16, reload, inactive
// - Timer 0 mode: 13, 16, reload, split
// - Clock bit 5 divides Timer 2 tick
// - Clock bit 4 divides Timer 1 tick
// - Clock bit 3 divides Timer 0 tick
// - Unused clock bits read zero, ignore writes
// - Counts readable and writable as two bytes
// - 13-bit mode: high byte plus five bits
// - Reload mode reloads low from high byte
// - Split high byte runs on Timer 1 run
// - Starting a timer keeps its count
package dtc_pkg;

    //=================================================================
    // Register addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h88;
    localparam logic [7:0] ADDR_MODE   = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
    localparam logic [7:0] ADDR_T0_HI  = 8'h8c;
    localparam logic [7:0] ADDR_T1_HI  = 8'h8d;
    localparam logic [7:0] ADDR_CLKDIV = 8'h8e;

    //=================================================================
    // Control register fields
    localparam int CTRL_T1_OVF  = 7;
    localparam int CTRL_T1_RUN  = 6;
    localparam int CTRL_T0_OVF  = 5;
    localparam int CTRL_T0_RUN  = 4;
    localparam int CTRL_X1_FLAG = 3;
    localparam int CTRL_X1_EDGE = 2;
    localparam int CTRL_X0_FLAG = 1;
    localparam int CTRL_X0_EDGE = 0;

    //=================================================================
    // Mode register fields
    localparam int MODE_T1_GATE = 7;
    localparam int MODE_SRC1  = 6;
    localparam int MODE_T1_HI = 5;
    localparam int MODE_T1_LO = 4;
    localparam int MODE_T0_GATE = 3;
    localparam int MODE_SRC0  = 2;
    localparam int MODE_T0_HI = 1;
    localparam int MODE_T0_LO = 0;

    //=================================================================
    // Clock divide register fields
    localparam int         CLK_T2_FAST = 5;
    localparam int         CLK_T1_FAST = 4;
    localparam int         CLK_T0_FAST = 3;
    localparam logic [7:0] CLKDIV_MASK = 8'h38;

    //=================================================================
    // Reset values and timing
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic       PIN_IDLE      = 1'b1;
    localparam int         PRESCALE_DIV  = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;
    localparam int         CNT13_LO_BITS = 5;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

    //=================================================================
    // Types
    typedef enum logic [1:0] {
        TM_13BIT,
        TM_16BIT,
        TM_RELOAD8,
        TM_SPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dtc_sfr_req_s;

    typedef struct packed {
        logic t0_count_pin;
        logic t1_count_pin;
        logic ext_interrupt0_pin;
        logic ext_interrupt1_pin;
    } dtc_pins_s;

    typedef struct packed {
        logic timer0;
        logic timer1;
        logic ext0;
        logic ext1;
    } dtc_vec_ack_s;

    typedef struct packed {
        logic       ovf;
        logic [7:0] low;
        logic [7:0] high;
    } dtc_step_s;

endpackage

// ==== rtl/dtc_timer_block.sv ====
// Dual timer/counter with external interrupt flags, SFR port access
`timescale 1ns/100ps
module dtc_timer_block
    import dtc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    // Register port
    input  wire dtc_sfr_req_s sfr_req,
    output logic [7:0]        sfr_rdata_ff,
    // Pins and vector acknowledges
    input  wire dtc_pins_s    pins,
    input  wire dtc_vec_ack_s vec_ack,
    // Interrupt flags and tick outputs
    output logic              timer1_overflow_flag_ff,
    output logic              timer0_overflow_flag_ff,
    output logic              ext_irq1_flag_ff,
    output logic              ext_irq0_flag_ff,
    output logic              timer1_overflow_pulse_ff,
    output logic              timer2_tick_ff
);

    //=================================================================
    // Register state
    logic       timer1_run_ff;
    logic       timer0_run_ff;
    logic       ext_irq1_edge_select_ff;
    logic       ext_irq0_edge_select_ff;
    logic [7:0] timer_mode_select_ff;
    logic [7:0] timer_clock_divide_ff;
    logic [7:0] timer0_count_low_ff;
    logic [7:0] timer0_count_high_ff;
    logic [7:0] timer1_count_low_ff;
    logic [7:0] timer1_count_high_ff;
    logic [3:0] prescale_ff;
    logic       t0_pin_prev_ff;
    logic       t1_pin_prev_ff;
    logic       ext_interrupt0_pin_pin_prev_ff;
    logic       ext_interrupt1_pin_pin_prev_ff;

    //=================================================================
    // Counting step shared by both timers
    function automatic dtc_step_s step_count(dtc_mode_e m,
                                             logic [7:0] lo,
                                             logic [7:0] hi);
        dtc_step_s   r;
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        r   = '{ovf: 1'b0, low: lo, high: hi};
        c13 = {1'b0, hi, lo[CNT13_LO_BITS-1:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h00001;
        c8  = {1'b0, lo} + 9'h001;
        case (m)
            TM_13BIT: begin
                // Upper three low-byte bits are left untouched
                r.high = c13[12:CNT13_LO_BITS];
                r.low  = {lo[7:CNT13_LO_BITS], c13[CNT13_LO_BITS-1:0]};
                r.ovf  = c13[13];
            end
            TM_16BIT: begin
                r.ovf  = c16[16];
                r.high = c16[15:8];
                r.low  = c16[7:0];
            end
            TM_RELOAD8: begin
                r.ovf = c8[8];
                r.low = c8[8] ? hi : c8[7:0];
            end
            default: begin
                r.ovf = c8[8];
                r.low = c8[7:0];
            end
        endcase
        return r;
    endfunction

    //=================================================================
    // Decode and control terms
    logic      wr_ctrl, wr_mode, wr_clk;
    logic      wr_t0l, wr_t0h, wr_t1l, wr_t1h;
    dtc_mode_e t0_mode, t1_mode;
    logic      t0_split, pre_tick, tick0, tick1;
    logic      fall_t0, fall_t1, fall_ext_interrupt0_pin, fall_ext_interrupt1_pin;
    logic      run0, run1, src0, src1, inc0, inc1, inc_hi0;
    logic      ovf0, ovf1, ovf_hi0, set_t1_flag;
    dtc_step_s s0, s1;

    assign wr_ctrl = sfr_req.wr && sfr_req.addr == ADDR_CTRL;
    assign wr_mode = sfr_req.wr && sfr_req.addr == ADDR_MODE;
    assign wr_clk  = sfr_req.wr && sfr_req.addr == ADDR_CLKDIV;
    assign wr_t0l  = sfr_req.wr && sfr_req.addr == ADDR_T0_LOW;
    assign wr_t0h  = sfr_req.wr && sfr_req.addr == ADDR_T0_HI;
    assign wr_t1l  = sfr_req.wr && sfr_req.addr == ADDR_T1_LOW;
    assign wr_t1h  = sfr_req.wr && sfr_req.addr == ADDR_T1_HI;

    assign t0_mode  = dtc_mode_e'(timer_mode_select_ff[MODE_T0_HI:MODE_T0_LO]);
    assign t1_mode  = dtc_mode_e'(timer_mode_select_ff[MODE_T1_HI:MODE_T1_LO]);
    assign t0_split = t0_mode == TM_SPLIT;

    // Pins are synchronous; a falling edge is seen in the first cycle the pin is low
    assign fall_t0   = t0_pin_prev_ff && !pins.t0_count_pin;
    assign fall_t1   = t1_pin_prev_ff && !pins.t1_count_pin;
    assign fall_ext_interrupt0_pin = ext_interrupt0_pin_pin_prev_ff && !pins.ext_interrupt0_pin;
    assign fall_ext_interrupt1_pin = ext_interrupt1_pin_pin_prev_ff && !pins.ext_interrupt1_pin;

    assign pre_tick = prescale_ff == PRESCALE_LAST;
    assign tick0 = timer_clock_divide_ff[CLK_T0_FAST] || pre_tick;
    assign tick1 = timer_clock_divide_ff[CLK_T1_FAST] || pre_tick;

    assign run0 = timer0_run_ff &&
        (!timer_mode_select_ff[MODE_T0_GATE] || pins.ext_interrupt0_pin);
    assign run1 = timer1_run_ff &&
        (!timer_mode_select_ff[MODE_T1_GATE] || pins.ext_interrupt1_pin);

    assign src0 = timer_mode_select_ff[MODE_SRC0] ? fall_t0 : tick0;
    // With Timer 0 split, Timer 1 loses its external clock
    assign src1 = (timer_mode_select_ff[MODE_SRC1] && !t0_split) ?
                  fall_t1 : tick1;

    assign inc0    = run0 && src0;
    assign inc1    = run1 && src1 && t1_mode != TM_SPLIT;
    assign inc_hi0 = t0_split && timer1_run_ff && tick0;

    assign s0 = step_count(t0_mode, timer0_count_low_ff,
                           timer0_count_high_ff);
    assign s1 = step_count(t1_mode, timer1_count_low_ff,
                           timer1_count_high_ff);

    assign ovf0    = inc0 && s0.ovf;
    assign ovf1    = inc1 && s1.ovf;
    assign ovf_hi0 = inc_hi0 && timer0_count_high_ff == BYTE_ALL_ONES;
    assign set_t1_flag = t0_split ? ovf_hi0 : ovf1;

    //=================================================================
    // Prescaler and pin history
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prescale_ff <= PRESCALE_ZERO;
        end else if (clk_en) begin
            prescale_ff <= pre_tick ? PRESCALE_ZERO : prescale_ff + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            t0_pin_prev_ff   <= PIN_IDLE;
            t1_pin_prev_ff   <= PIN_IDLE;
            ext_interrupt0_pin_pin_prev_ff <= PIN_IDLE;
            ext_interrupt1_pin_pin_prev_ff <= PIN_IDLE;
        end else if (clk_en) begin
            t0_pin_prev_ff   <= pins.t0_count_pin;
            t1_pin_prev_ff   <= pins.t1_count_pin;
            ext_interrupt0_pin_pin_prev_ff <= pins.ext_interrupt0_pin;
            ext_interrupt1_pin_pin_prev_ff <= pins.ext_interrupt1_pin;
        end
    end

    //=================================================================
    // Configuration registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer1_run_ff           <= 1'b0;
            timer0_run_ff           <= 1'b0;
            ext_irq1_edge_select_ff <= 1'b0;
            ext_irq0_edge_select_ff <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            timer1_run_ff           <= sfr_req.wdata[CTRL_T1_RUN];
            timer0_run_ff           <= sfr_req.wdata[CTRL_T0_RUN];
            ext_irq1_edge_select_ff <= sfr_req.wdata[CTRL_X1_EDGE];
            ext_irq0_edge_select_ff <= sfr_req.wdata[CTRL_X0_EDGE];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer_mode_select_ff  <= REG_RESET;
            timer_clock_divide_ff <= REG_RESET;
        end else if (clk_en) begin
            if (wr_mode) begin
                timer_mode_select_ff <= sfr_req.wdata;
            end
            if (wr_clk) begin
                timer_clock_divide_ff <= sfr_req.wdata & CLKDIV_MASK;
            end
        end
    end

    //=================================================================
    // Overflow flags: a set beats a clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer0_overflow_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (ovf0) begin
                timer0_overflow_flag_ff <= 1'b1;
            end else if (vec_ack.timer0) begin
                timer0_overflow_flag_ff <= 1'b0;
            end else if (wr_ctrl) begin
                timer0_overflow_flag_ff <= sfr_req.wdata[CTRL_T0_OVF];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer1_overflow_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (set_t1_flag) begin
                timer1_overflow_flag_ff <= 1'b1;
            end else if (vec_ack.timer1) begin
                timer1_overflow_flag_ff <= 1'b0;
            end else if (wr_ctrl) begin
                timer1_overflow_flag_ff <= sfr_req.wdata[CTRL_T1_OVF];
            end
        end
    end

    //=================================================================
    // External interrupt flags
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ext_irq0_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (!ext_irq0_edge_select_ff) begin
                ext_irq0_flag_ff <= !pins.ext_interrupt0_pin;
            end else if (fall_ext_interrupt0_pin) begin
                ext_irq0_flag_ff <= 1'b1;
            end else if (vec_ack.ext0) begin
                ext_irq0_flag_ff <= 1'b0;
            end else if (wr_ctrl) begin
                ext_irq0_flag_ff <= sfr_req.wdata[CTRL_X0_FLAG];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ext_irq1_flag_ff <= 1'b0;
        end else if (clk_en) begin
            if (!ext_irq1_edge_select_ff) begin
                ext_irq1_flag_ff <= !pins.ext_interrupt1_pin;
            end else if (fall_ext_interrupt1_pin) begin
                ext_irq1_flag_ff <= 1'b1;
            end else if (vec_ack.ext1) begin
                ext_irq1_flag_ff <= 1'b0;
            end else if (wr_ctrl) begin
                ext_irq1_flag_ff <= sfr_req.wdata[CTRL_X1_FLAG];
            end
        end
    end

    //=================================================================
    // Timer 0 count bytes; a software write beats counting
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer0_count_low_ff  <= REG_RESET;
            timer0_count_high_ff <= REG_RESET;
        end else if (clk_en) begin
            if (wr_t0l) begin
                timer0_count_low_ff <= sfr_req.wdata;
            end else if (inc0) begin
                timer0_count_low_ff <= s0.low;
            end
            if (wr_t0h) begin
                timer0_count_high_ff <= sfr_req.wdata;
            end else if (inc_hi0) begin
                timer0_count_high_ff <= timer0_count_high_ff + 8'h01;
            end else if (inc0 && !t0_split) begin
                timer0_count_high_ff <= s0.high;
            end
        end
    end

    //=================================================================
    // Timer 1 count bytes
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer1_count_low_ff  <= REG_RESET;
            timer1_count_high_ff <= REG_RESET;
        end else if (clk_en) begin
            if (wr_t1l) begin
                timer1_count_low_ff <= sfr_req.wdata;
            end else if (inc1) begin
                timer1_count_low_ff <= s1.low;
            end
            if (wr_t1h) begin
                timer1_count_high_ff <= sfr_req.wdata;
            end else if (inc1) begin
                timer1_count_high_ff <= s1.high;
            end
        end
    end

    //=================================================================
    // Tick outputs for the serial port and Timer 2
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer1_overflow_pulse_ff <= 1'b0;
            timer2_tick_ff           <= 1'b0;
        end else if (clk_en) begin
            // Kept even when split mode blocks the flag, for baud use
            timer1_overflow_pulse_ff <= ovf1;
            timer2_tick_ff <= timer_clock_divide_ff[CLK_T2_FAST] || pre_tick;
        end else begin
            timer1_overflow_pulse_ff <= 1'b0;
            timer2_tick_ff           <= 1'b0;
        end
    end

    //=================================================================
    // Read data, one cycle after the address
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sfr_rdata_ff <= REG_RESET;
        end else if (clk_en) begin
            case (sfr_req.addr)
                ADDR_CTRL:   sfr_rdata_ff <= {timer1_overflow_flag_ff,
                                              timer1_run_ff,
                                              timer0_overflow_flag_ff,
                                              timer0_run_ff,
                                              ext_irq1_flag_ff,
                                              ext_irq1_edge_select_ff,
                                              ext_irq0_flag_ff,
                                              ext_irq0_edge_select_ff};
                ADDR_MODE:   sfr_rdata_ff <= timer_mode_select_ff;
                ADDR_CLKDIV: sfr_rdata_ff <= timer_clock_divide_ff;
                ADDR_T0_LOW: sfr_rdata_ff <= timer0_count_low_ff;
                ADDR_T0_HI:  sfr_rdata_ff <= timer0_count_high_ff;
                ADDR_T1_LOW: sfr_rdata_ff <= timer1_count_low_ff;
                ADDR_T1_HI:  sfr_rdata_ff <= timer1_count_high_ff;
                default:     sfr_rdata_ff <= REG_RESET;
            endcase
        end
    end

    //=================================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_reload_wrap;
        clk_en && inc0 && t0_mode == TM_RELOAD8 && !wr_t0l && !wr_t0h &&
        timer0_count_low_ff == BYTE_ALL_ONES;
    endsequence

    a_t0_ovf_set: assert property (
        clk_en && ovf0 |=> timer0_overflow_flag_ff)
        else $error("Timer 0 overflow did not set its flag");

    a_t1_ovf_set: assert property (
        clk_en && set_t1_flag |=> timer1_overflow_flag_ff)
        else $error("Timer 1 overflow did not set its flag");

    a_t0_ack_clear: assert property (
        clk_en && vec_ack.timer0 && !ovf0 |=> !timer0_overflow_flag_ff)
        else $error("Vector acknowledge did not clear Timer 0 flag");

    a_stop_holds_count: assert property (
        clk_en && !timer0_run_ff && !t0_split && !wr_t0l && !wr_t0h
        |=> $stable(timer0_count_low_ff) && $stable(timer0_count_high_ff))
        else $error("Stopped Timer 0 changed its count");

    a_gate_blocks: assert property (
        clk_en && timer_mode_select_ff[MODE_T1_GATE] &&
        !pins.ext_interrupt1_pin && !wr_t1l && !wr_t1h
        |=> $stable(timer1_count_low_ff))
        else $error("Gated Timer 1 counted with pin low");

    a_x0_level: assert property (
        clk_en && !ext_irq0_edge_select_ff
        |=> ext_irq0_flag_ff == !$past(pins.ext_interrupt0_pin))
        else $error("Level irq 0 flag did not follow the pin");

    a_x1_edge_set: assert property (
        clk_en && ext_irq1_edge_select_ff && fall_ext_interrupt1_pin |=> ext_irq1_flag_ff)
        else $error("Falling edge did not set irq 1 flag");

    a_reload_value: assert property (
        s_reload_wrap |=> timer0_count_low_ff == $past(timer0_count_high_ff)
                          && $stable(timer0_count_high_ff)
                          && timer0_overflow_flag_ff)
        else $error("Reload mode wrap did not reload from high byte");

    a_clkdiv_unused: assert property (
        clk_en && sfr_req.addr == ADDR_CLKDIV
        |=> (sfr_rdata_ff & ~CLKDIV_MASK) == REG_RESET)
        else $error("Unused clock divide bits read non-zero");

    a_div12_tick: assert property (
        clk_en && pre_tick ##1 clk_en[*8]
        |-> !pre_tick)
        else $error("Prescale tick came sooner than divide period");

endmodule // dtc_timer_block

// ==== testbench/dtc_pin_model.sv ====
// Pin-side partner: event, gate and interrupt pins of the block
`timescale 1ns/100ps
module dtc_pin_model
    import dtc_pkg::*;
(
    // Clock and requested levels
    input  wire logic      sys_clk,
    input  wire dtc_pins_s want,
    // Pins toward the block
    output dtc_pins_s      pins
);
    //=================================================================
    // Levels move only after a falling edge, so sampling never races
    dtc_pins_s held = '1;
    initial pins = '1;
    always @(posedge sys_clk) begin
        held <= want;
    end
    always @(negedge sys_clk) begin
        pins <= held;
    end
endmodule // dtc_pin_model

// ==== testbench/dtc_timer_block_tb.sv ====
// Self-checking bench of the dual timer/counter block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dtc_timer_block_tb;
    import dtc_pkg::*;
    logic         sys_clk;
    logic         reset;
    dtc_sfr_req_s req;
    logic [7:0]   rdata;
    dtc_pins_s    want;
    dtc_pins_s    pins;
    dtc_vec_ack_s ack;
    logic         t1f, t0f, x1f, x0f, t1p, t2t, en;
    int           mismatches, checks, seed, n;
    logic [7:0]   a, d, q;

    //=================================================================
    // Design and partner
    dtc_timer_block u_dut (.sys_clk(sys_clk), .reset(reset),
        .clk_en(en), .sfr_req(req), .sfr_rdata_ff(rdata),
        .pins(pins), .vec_ack(ack), .timer1_overflow_flag_ff(t1f),
        .timer0_overflow_flag_ff(t0f), .ext_irq1_flag_ff(x1f),
        .ext_irq0_flag_ff(x0f), .timer1_overflow_pulse_ff(t1p),
        .timer2_tick_ff(t2t));
    dtc_pin_model u_pins (.sys_clk(sys_clk), .want(want), .pins(pins));

    //=================================================================
    // Bus, pin and vector tasks
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(negedge sys_clk) req = '{1'b1, ad, v};
        @(negedge sys_clk) req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] v);
        @(negedge sys_clk) req.addr = ad;
        @(negedge sys_clk) v = rdata;
    endtask
    task automatic pulse(input dtc_vec_ack_s m);
        @(negedge sys_clk) ack = m;
        @(negedge sys_clk) ack = '0;
    endtask
    task automatic setpin(input int i, input logic v);
        if (i == 0) want.ext_interrupt0_pin = v;
        else want.ext_interrupt1_pin = v;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic wait_flag(ref logic f);
        n = 0;
        while (f !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    function automatic logic [7:0] exp_rd(input logic [7:0] ad,
                                          input logic [7:0] v);
        if (ad == ADDR_CLKDIV) return v & CLKDIV_MASK;
        return (ad > ADDR_CLKDIV) ? 8'h00 : v;
    endfunction
    task automatic print_verdict;
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    //=================================================================
    // Clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        mismatches++;
        print_verdict;
    end
    initial begin
        req = '0; want = '1; ack = '0; reset = 1'b1; seed = 65090;
        mismatches = 0; checks = 0; en = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(ADDR_CTRL + 8'(i), d);
            `CHK(d, REG_RESET)
        end
        // Timers stopped: bytes read back as written, clock divide masked, the address past it as zero
        for (int i = 0; i < 14; i++) begin
            a = 8'(8'h89 + {$random(seed)} % 7);
            d = 8'($random(seed));
            wr(a, d);
            rd(a, q);
            `CHK(q, exp_rd(a, d))
        end
        wr(ADDR_MODE, 8'h01); wr(ADDR_CLKDIV, 8'h08);
        wr(ADDR_T0_LOW, 8'hfd); wr(ADDR_T0_HI, 8'hff);
        rd(ADDR_T0_LOW, d);
        `CHK(d, 8'hfd)
        wr(ADDR_CTRL, 8'h10);
        wait_flag(t0f);
        `CHK(t0f, 1'b1)
        pulse(dtc_vec_ack_s'(4'b1000));
        `CHK(t0f, 1'b0)
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_T0_LOW, d);
        repeat (5) @(negedge sys_clk);
        rd(ADDR_T0_LOW, q);
        `CHK(q, d)
        // Reload mode on the slow tick: stop before the next tick lands
        wr(ADDR_MODE, 8'h20); wr(ADDR_CLKDIV, 8'h00);
        wr(ADDR_T1_HI, 8'hf0); wr(ADDR_T1_LOW, 8'hfe);
        wr(ADDR_CTRL, 8'h40);
        wait_flag(t1f);
        `CHK(t1f, 1'b1)
        `CHK(t1p, 1'b1)
        `CHK(n >= 11, 1'b1)
        wr(ADDR_CTRL, 8'h00);
        `CHK(t1f, 1'b0)
        rd(ADDR_T1_LOW, d);
        `CHK(d, 8'hf0)
        rd(ADDR_T1_HI, d);
        `CHK(d, 8'hf0)
        wr(ADDR_T0_LOW, 8'h00); wr(ADDR_MODE, 8'h05);
        wr(ADDR_CTRL, 8'h10);
        for (int i = 0; i < 3; i++) begin
            want.t0_count_pin = 1'b0;
            repeat (3) @(negedge sys_clk);
            want.t0_count_pin = 1'b1;
            repeat (3) @(negedge sys_clk);
        end
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_T0_LOW, d);
        `CHK(d, 8'h03)
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 8'h01 << (2 * i));
            setpin(i, 1'b0);
            `CHK(i == 0 ? x0f : x1f, 1'b1)
            setpin(i, 1'b1);
            `CHK(i == 0 ? x0f : x1f, 1'b1)
            pulse(dtc_vec_ack_s'(4'b0010 >> i));
            `CHK(i == 0 ? x0f : x1f, 1'b0)
            wr(ADDR_CTRL, 8'h00);
            setpin(i, 1'b0);
            `CHK(i == 0 ? x0f : x1f, 1'b1)
            setpin(i, 1'b1);
            `CHK(i == 0 ? x0f : x1f, 1'b0)
        end
        // Gate held closed by a low pin: the count must not move
        wr(ADDR_MODE, 8'h09); wr(ADDR_CLKDIV, 8'h28);
        wr(ADDR_T0_LOW, 8'h00); setpin(0, 1'b0);
        wr(ADDR_CTRL, 8'h10);
        repeat (5) @(negedge sys_clk);
        `CHK(t2t, 1'b1)
        rd(ADDR_T0_LOW, d);
        `CHK(d, 8'h00)
        // Enable low freezes the counts and clears the ticks: the opened gate counts only after it
        en = 1'b0;
        setpin(0, 1'b1);
        `CHK(t2t, 1'b0)
        en = 1'b1;
        rd(ADDR_T0_LOW, d);
        `CHK(d, 8'h01)
        print_verdict;
    end
endmodule // dtc_timer_block_tb
